// ### src/trs_defines.svh
`ifndef TRS_DEFINES_SVH
`define TRS_DEFINES_SVH

// Fixed latency of the slice and region-of-interest pipelines, in ticks.
`define TRS_PIPE_DEPTH 48
// Largest offset between level-1 accept and readout trigger, in ticks.
`define TRS_MAX_OFFSET 16
`define TRS_OFFSET_BITS 5
// Readout slice count limits.
`define TRS_MIN_SLICES 1
`define TRS_MAX_SLICES 5
`define TRS_SLICE_BITS 3
// Derandomiser depth in words.
`define TRS_FIFO_DEPTH 256
// Input processors and their sampled link words.
`define TRS_PROC_COUNT 11
`define TRS_WORDS_PER_PROC 8
`define TRS_LINK_WORD_BITS 11
// Bunch count identifier and trigger result widths.
`define TRS_BCID_BITS 12
`define TRS_RESULT_BITS 24
// Region-of-interest record layout.
`define TRS_JET_COUNT 8
`define TRS_THRESH_BITS 8
`define TRS_POS_BITS 2
// Stream layout: payload bits per lane, parity excluded.
`define TRS_DAQ_LANES 13
`define TRS_DAQ_PAYLOAD 88
`define TRS_ROI_LANES 2
`define TRS_ROI_PAYLOAD 48
// Bunch count bits carried on each region-of-interest lane.
`define TRS_ROI_BCID_BITS 4

`endif

// ### src/trs_pkg.sv
package trs_pkg;
`include "trs_defines.svh"

typedef logic [`TRS_LINK_WORD_BITS-1:0] trs_link_word_type;
typedef trs_link_word_type [`TRS_WORDS_PER_PROC-1:0] trs_proc_slice_type;

typedef struct packed {
    logic [`TRS_POS_BITS-1:0] position;
    logic saturated;
    logic [`TRS_THRESH_BITS-1:0] thresholds;
} trs_jet_type;

typedef struct packed {
    logic [`TRS_BCID_BITS-1:0] bcid;
    logic [`TRS_RESULT_BITS:0] jet_count_word;
    logic [`TRS_RESULT_BITS:0] energy_word;
    trs_proc_slice_type [`TRS_PROC_COUNT-1:0] proc;
} trs_slice_type;

typedef struct packed {
    logic [`TRS_BCID_BITS-1:0] bcid;
    trs_jet_type [`TRS_JET_COUNT-1:0] jets;
} trs_roi_type;

typedef enum logic [1:0] {
    TRS_IDLE,
    TRS_SHIFT,
    TRS_PARITY,
    TRS_SEPARATE
} trs_ser_state_type;

endpackage : trs_pkg

// ### src/trs_fifo.sv
`timescale 1ns/100ps
module trs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != FULL_COUNT);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST_ADDR) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST_ADDR) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end
endmodule : trs_fifo

// ### src/trs_serialiser.sv
`timescale 1ns/100ps
module trs_serialiser
    import trs_pkg::*;
#(
    parameter int LANES = 2,
    parameter int PAYLOAD = 48
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Word input, last marks the final word of an event
    input wire logic in_valid,
    output logic in_ready,
    input wire logic in_last,
    input wire logic [LANES*PAYLOAD-1:0] in_data,
    // Serial output
    output logic [LANES-1:0] serial_data,
    output logic serial_valid
);
    localparam int CW = $clog2(PAYLOAD);
    localparam logic [CW-1:0] LAST_BIT = CW'(PAYLOAD - 1);

    trs_ser_state_type state;
    logic [LANES*PAYLOAD-1:0] shifter;
    logic [LANES*PAYLOAD-1:0] next_shifter;
    logic [LANES-1:0] top_bits;
    logic [LANES-1:0] parity;
    logic [CW-1:0] bit_count;
    logic word_last;
    logic take;

    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            top_bits[l] = shifter[l*PAYLOAD + PAYLOAD - 1];
            next_shifter[l*PAYLOAD +: PAYLOAD] =
                {shifter[l*PAYLOAD +: PAYLOAD-1], 1'b0};
        end
    end

    // A word is taken from idle, right after a separator, or straight after
    // the parity bit of a non-final slice so slices of one event abut.
    assign in_ready = (state == TRS_IDLE) || (state == TRS_SEPARATE) ||
                      ((state == TRS_PARITY) && !word_last);
    assign take = in_valid && in_ready;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state <= TRS_IDLE;
            shifter <= '0;
            parity <= '0;
            bit_count <= '0;
            word_last <= 1'b0;
        end else begin
            if (take) begin
                shifter <= in_data;
                word_last <= in_last;
                parity <= '0;
                bit_count <= '0;
            end
            unique case (state)
                TRS_IDLE, TRS_SEPARATE: begin
                    state <= take ? TRS_SHIFT : TRS_IDLE;
                end
                TRS_SHIFT: begin
                    shifter <= next_shifter;
                    parity <= parity ^ top_bits;
                    bit_count <= bit_count + 1'b1;
                    if (bit_count == LAST_BIT) begin
                        state <= TRS_PARITY;
                    end
                end
                TRS_PARITY: begin
                    if (word_last) begin
                        state <= TRS_SEPARATE;
                    end else begin
                        state <= take ? TRS_SHIFT : TRS_IDLE;
                    end
                end
            endcase
        end
    end

    // One bit per lane leaves on every tick of a shift or parity state.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            serial_data <= '0;
            serial_valid <= 1'b0;
        end else begin
            unique case (state)
                TRS_SHIFT: begin
                    serial_data <= top_bits;
                    serial_valid <= 1'b1;
                end
                TRS_PARITY: begin
                    serial_data <= ~parity;
                    serial_valid <= 1'b1;
                end
                TRS_IDLE, TRS_SEPARATE: begin
                    serial_data <= '0;
                    serial_valid <= 1'b0;
                end
            endcase
        end
    end
endmodule : trs_serialiser

// ### src/trs_readout.sv
// Operation
// - Delay all sampled data 48 ticks.
// - Readout trigger follows accept by programmed offset.
// - Trigger lasts one to five ticks.
// - Copy slice outputs into FIFOs while triggered, region output on first tick only.
// - Slice holds eight 11-bit link words per processor.
// - Bunch count identifier stored with slice data.
// - Trigger results carry odd parity bits.
// - Region record: eight jets, position, saturation, thresholds.
// - Thirteen single-bit DAQ streams leave the block.
// - Region data leaves on two-bit stream.
// - Transmission starts at once into empty FIFOs.
// - Transmission continues until FIFOs drain.
// - One separator bit between successive events.
// - Packets 89 bits per slice, region 49.
// - Streams presented 13 and 2 bits wide.
// - Data valid low during separator bit.
// - One bit per stream per tick.
// - Neighbour copies are never captured.
`timescale 1ns/100ps
`include "trs_defines.svh"
module trs_readout
    import trs_pkg::*;
#(
    parameter int PIPE_DEPTH = `TRS_PIPE_DEPTH,
    parameter int FIFO_DEPTH = `TRS_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Level-1 accept from the timing path, asynchronous to mclk
    input wire logic level1_accept_input,
    // Control settings from the board control logic
    input wire logic [`TRS_OFFSET_BITS-1:0] read_offset,
    input wire logic [`TRS_SLICE_BITS-1:0] slice_count,
    // Real-time samples, one set per tick
    input wire trs_proc_slice_type [`TRS_PROC_COUNT-1:0] link_samples,
    input wire logic [`TRS_BCID_BITS-1:0] bunch_count_id,
    input wire logic [`TRS_RESULT_BITS-1:0] jet_count,
    input wire logic [`TRS_RESULT_BITS-1:0] energy_sum,
    input wire trs_jet_type [`TRS_JET_COUNT-1:0] roi_jets,
    // DAQ streams towards the readout controller
    output logic [`TRS_DAQ_LANES-1:0] daq_stream,
    output logic daq_stream_data_valid,
    // Region-of-interest stream towards the readout controller
    output logic [`TRS_ROI_LANES-1:0] roi_stream,
    output logic roi_stream_data_valid,
    // Status
    output logic readout_trigger,
    output logic readout_overflow
);
    localparam int DAQ_WIDTH = `TRS_DAQ_LANES * `TRS_DAQ_PAYLOAD;
    localparam int ROI_WIDTH = `TRS_ROI_LANES * `TRS_ROI_PAYLOAD;
    localparam int MAIN_PAD = `TRS_DAQ_PAYLOAD - 2 * (`TRS_RESULT_BITS + 1);
    localparam int BCID_PAD = `TRS_DAQ_PAYLOAD - `TRS_BCID_BITS;
    localparam int ROI_HALF = `TRS_JET_COUNT / 2;
    localparam logic [`TRS_OFFSET_BITS-1:0] MAX_OFFSET =
        `TRS_OFFSET_BITS'(`TRS_MAX_OFFSET);
    localparam logic [`TRS_SLICE_BITS-1:0] MIN_SLICES =
        `TRS_SLICE_BITS'(`TRS_MIN_SLICES);
    localparam logic [`TRS_SLICE_BITS-1:0] MAX_SLICES =
        `TRS_SLICE_BITS'(`TRS_MAX_SLICES);

    // The accept comes from another clock domain and is synchronised first.
    logic accept_meta;
    logic accept_sync;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            accept_meta <= 1'b0;
            accept_sync <= 1'b0;
        end else begin
            accept_meta <= level1_accept_input;
            accept_sync <= accept_meta;
        end
    end

    // Sample assembly. Only local link words and local results are taken;
    // jet elements shared with neighbouring modules have no port at all.
    trs_slice_type slice_now;
    trs_roi_type roi_now;

    always_comb begin
        slice_now.bcid = bunch_count_id;
        slice_now.jet_count_word = {~^jet_count, jet_count};
        slice_now.energy_word = {~^energy_sum, energy_sum};
        slice_now.proc = link_samples;
        roi_now.bcid = bunch_count_id;
        roi_now.jets = roi_jets;
    end

    // Latency pipelines.
    trs_slice_type slice_pipe [PIPE_DEPTH];
    trs_roi_type roi_pipe [PIPE_DEPTH];

    always_ff @(posedge mclk) begin
        slice_pipe[0] <= slice_now;
        roi_pipe[0] <= roi_now;
        for (int i = 1; i < PIPE_DEPTH; i++) begin
            slice_pipe[i] <= slice_pipe[i-1];
            roi_pipe[i] <= roi_pipe[i-1];
        end
    end

    // Settings in use. They are copied only while no accept is on its way
    // and no trigger is active, so an event is never read with mixed values.
    logic [`TRS_OFFSET_BITS-1:0] offset_used;
    logic [`TRS_SLICE_BITS-1:0] slices_used;
    logic [`TRS_MAX_OFFSET-1:0] accept_line;
    logic [`TRS_MAX_OFFSET:0] accept_taps;
    logic quiet;

    assign accept_taps = {accept_line, accept_sync};
    assign quiet = !readout_trigger && !accept_sync && (accept_line == '0);

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            offset_used <= '0;
            slices_used <= MIN_SLICES;
        end else if (quiet) begin
            offset_used <= (read_offset > MAX_OFFSET) ? MAX_OFFSET
                                                      : read_offset;
            if (slice_count < MIN_SLICES) begin
                slices_used <= MIN_SLICES;
            end else if (slice_count > MAX_SLICES) begin
                slices_used <= MAX_SLICES;
            end else begin
                slices_used <= slice_count;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            accept_line <= '0;
        end else begin
            accept_line <= accept_taps[`TRS_MAX_OFFSET-1:0];
        end
    end

    logic accept_delayed;

    assign accept_delayed = accept_taps[offset_used];

    // Readout trigger. A delayed accept that lands inside an active trigger
    // is dropped; accepts are normally spaced wider than five ticks.
    logic [`TRS_SLICE_BITS-1:0] ticks_left;
    logic first_tick;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            readout_trigger <= 1'b0;
            ticks_left <= '0;
            first_tick <= 1'b0;
        end else if (!readout_trigger) begin
            if (accept_delayed) begin
                readout_trigger <= 1'b1;
                ticks_left <= slices_used - 1'b1;
                first_tick <= 1'b1;
            end
        end else begin
            first_tick <= 1'b0;
            if (ticks_left == '0) begin
                readout_trigger <= 1'b0;
            end else begin
                ticks_left <= ticks_left - 1'b1;
            end
        end
    end

    // Mapping of pipeline outputs onto stream lanes.
    logic [DAQ_WIDTH-1:0] daq_word;
    logic [ROI_WIDTH-1:0] roi_word;
    trs_slice_type slice_out;
    trs_roi_type roi_out;

    assign slice_out = slice_pipe[PIPE_DEPTH-1];
    assign roi_out = roi_pipe[PIPE_DEPTH-1];

    always_comb begin
        for (int p = 0; p < `TRS_PROC_COUNT; p++) begin
            daq_word[p*`TRS_DAQ_PAYLOAD +: `TRS_DAQ_PAYLOAD] =
                slice_out.proc[p];
        end
        daq_word[`TRS_PROC_COUNT*`TRS_DAQ_PAYLOAD +: `TRS_DAQ_PAYLOAD] =
            {{MAIN_PAD{1'b0}}, slice_out.jet_count_word,
             slice_out.energy_word};
        daq_word[(`TRS_PROC_COUNT+1)*`TRS_DAQ_PAYLOAD +: `TRS_DAQ_PAYLOAD] =
            {{BCID_PAD{1'b0}}, slice_out.bcid};
        roi_word[0 +: `TRS_ROI_PAYLOAD] =
            {roi_out.bcid[`TRS_ROI_BCID_BITS-1:0],
             roi_out.jets[ROI_HALF-1:0]};
        roi_word[`TRS_ROI_PAYLOAD +: `TRS_ROI_PAYLOAD] =
            {roi_out.bcid[2*`TRS_ROI_BCID_BITS-1:`TRS_ROI_BCID_BITS],
             roi_out.jets[`TRS_JET_COUNT-1:ROI_HALF]};
    end

    // Derandomisers. A full FIFO refuses the word; the loss is flagged
    // rather than stalling the fixed-latency pipeline, which cannot wait.
    logic daq_in_ready;
    logic roi_in_ready;
    logic daq_push;
    logic roi_push;
    logic daq_out_valid;
    logic daq_out_ready;
    logic [DAQ_WIDTH:0] daq_out_data;
    logic roi_out_valid;
    logic roi_out_ready;
    logic [ROI_WIDTH-1:0] roi_out_data;

    assign daq_push = readout_trigger;
    assign roi_push = readout_trigger && first_tick;

    trs_fifo #(
        .WIDTH(DAQ_WIDTH + 1),
        .DEPTH(FIFO_DEPTH)
    ) u_daq_fifo (
        .mclk(mclk),
        .resetn(resetn),
        .in_valid(daq_push),
        .in_ready(daq_in_ready),
        .in_data({ticks_left == '0, daq_word}),
        .out_valid(daq_out_valid),
        .out_ready(daq_out_ready),
        .out_data(daq_out_data)
    );

    trs_fifo #(
        .WIDTH(ROI_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_roi_fifo (
        .mclk(mclk),
        .resetn(resetn),
        .in_valid(roi_push),
        .in_ready(roi_in_ready),
        .in_data(roi_word),
        .out_valid(roi_out_valid),
        .out_ready(roi_out_ready),
        .out_data(roi_out_data)
    );

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            readout_overflow <= 1'b0;
        end else if ((daq_push && !daq_in_ready) ||
                     (roi_push && !roi_in_ready)) begin
            readout_overflow <= 1'b1;
        end
    end

    // Serialisers.
    trs_serialiser #(
        .LANES(`TRS_DAQ_LANES),
        .PAYLOAD(`TRS_DAQ_PAYLOAD)
    ) u_daq_ser (
        .mclk(mclk),
        .resetn(resetn),
        .in_valid(daq_out_valid),
        .in_ready(daq_out_ready),
        .in_last(daq_out_data[DAQ_WIDTH]),
        .in_data(daq_out_data[DAQ_WIDTH-1:0]),
        .serial_data(daq_stream),
        .serial_valid(daq_stream_data_valid)
    );

    trs_serialiser #(
        .LANES(`TRS_ROI_LANES),
        .PAYLOAD(`TRS_ROI_PAYLOAD)
    ) u_roi_ser (
        .mclk(mclk),
        .resetn(resetn),
        .in_valid(roi_out_valid),
        .in_ready(roi_out_ready),
        .in_last(1'b1),
        .in_data(roi_out_data),
        .serial_data(roi_stream),
        .serial_valid(roi_stream_data_valid)
    );
endmodule : trs_readout

// ### tb/trs_readout_monitor.sv
`timescale 1ns/100ps
module trs_readout_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Watched ports
    input wire logic level1_accept_input,
    input wire logic [4:0] read_offset,
    input wire logic [2:0] slice_count,
    input wire logic [12:0] daq_stream,
    input wire logic daq_stream_data_valid,
    input wire logic [1:0] roi_stream,
    input wire logic roi_stream_data_valid,
    input wire logic readout_trigger,
    input wire logic readout_overflow
);
    int age, tlen, dlen, rlen, bit_n, n_exp, o_exp;
    logic [12:0] par;
    logic dv;

    assign dv = daq_stream_data_valid;
    assign n_exp = slice_count == 3'h0 ? 1 :
        slice_count > 3'h5 ? 5 : slice_count;
    assign o_exp = read_offset > 5'h10 ? 16 : read_offset;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    // Ticks since the last accept edge, parked at 1000 once long gone.
    always_ff @(posedge mclk) begin
        if (!resetn || $rose(level1_accept_input))
            age <= resetn ? 0 : 1000;
        else if (age < 1000)
            age <= age + 1;
    end
    always_ff @(posedge mclk) begin
        tlen <= readout_trigger ? tlen + 1 : 0;
        dlen <= dv ? dlen + 1 : 0;
        rlen <= roi_stream_data_valid ? rlen + 1 : 0;
    end
    always_ff @(posedge mclk) begin
        bit_n <= (dv && bit_n != 88) ? bit_n + 1 : 0;
        par <= (dv && bit_n != 88) ? par ^ daq_stream : 13'h0000;
    end

    sequence s_quiet;
        (!dv && !readout_trigger) [*5];
    endsequence
    sequence s_launch;
        !dv [*3] ##1 dv;
    endsequence

    a_trig_delay: assert property (
        $rose(readout_trigger) |-> age == o_exp + 2)
        else $error("Trigger delay differs from the offset.");
    a_trig_length: assert property (
        $fell(readout_trigger) |-> tlen == n_exp)
        else $error("Trigger length differs from the slice count.");
    a_stream_start: assert property (
        s_quiet ##1 $rose(readout_trigger) |-> s_launch)
        else $error("Idle stream did not start on time.");
    a_daq_length: assert property (
        $fell(dv) && !readout_overflow |-> dlen == 89 * n_exp)
        else $error("Slice packet length wrong.");
    a_roi_length: assert property (
        $fell(roi_stream_data_valid) |-> rlen == 49)
        else $error("Region packet length wrong.");
    a_sep_after: assert property (
        dv && dlen == 89 * n_exp - 1 && !readout_overflow |=> !dv)
        else $error("No separator after the event.");
    a_sep_zero: assert property (
        (dv || daq_stream == 13'h0000) &&
        (roi_stream_data_valid || roi_stream == 2'h0))
        else $error("Stream data not zero outside packets.");
    a_parity_odd: assert property (
        dv && bit_n == 88 |-> (par ^ daq_stream) == 13'h1FFF)
        else $error("Slice parity not odd.");
    a_overflow_sticky: assert property (
        readout_overflow |=> readout_overflow)
        else $error("Overflow flag cleared without reset.");
    a_reset_quiet: assert property (
        $rose(resetn) |-> !readout_trigger && !dv && !readout_overflow)
        else $error("Outputs active right after reset.");
endmodule : trs_readout_monitor

bind trs_readout trs_readout_monitor u_mon (
    .mclk(mclk), .resetn(resetn),
    .level1_accept_input(level1_accept_input),
    .read_offset(read_offset), .slice_count(slice_count),
    .daq_stream(daq_stream), .daq_stream_data_valid(daq_stream_data_valid),
    .roi_stream(roi_stream), .roi_stream_data_valid(roi_stream_data_valid),
    .readout_trigger(readout_trigger), .readout_overflow(readout_overflow)
);

// ### tb/trs_collector.sv
`timescale 1ns/100ps
module trs_collector (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Streams from the readout block
    input wire logic [12:0] daq_stream,
    input wire logic daq_stream_data_valid,
    input wire logic [1:0] roi_stream,
    input wire logic roi_stream_data_valid,
    // Gathered packets, newest bit at the bottom
    output logic [12:0][444:0] daq_pkt,
    output int daq_len,
    output int daq_events,
    output logic [1:0][48:0] roi_pkt,
    output int roi_len,
    output int roi_events
);
    int drun, rrun;

    // A falling valid is the only event boundary the link carries, so a
    // missing separator would merge two events here.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            drun <= 0;
            daq_events <= 0;
        end else if (daq_stream_data_valid) begin
            for (int l = 0; l < 13; l++)
                daq_pkt[l] <= {daq_pkt[l][443:0], daq_stream[l]};
            drun <= drun + 1;
        end else if (drun > 0) begin
            daq_len <= drun;
            daq_events <= daq_events + 1;
            drun <= 0;
        end
    end
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rrun <= 0;
            roi_events <= 0;
        end else if (roi_stream_data_valid) begin
            for (int l = 0; l < 2; l++)
                roi_pkt[l] <= {roi_pkt[l][47:0], roi_stream[l]};
            rrun <= rrun + 1;
        end else if (rrun > 0) begin
            roi_len <= rrun;
            roi_events <= roi_events + 1;
            rrun <= 0;
        end
    end
endmodule : trs_collector

// ### tb/trs_readout_tb.sv
`timescale 1ns/100ps
module trs_readout_tb
    import trs_pkg::*;
;
    logic mclk;
    logic resetn = 1'b0;
    logic acc = 1'b0;
    logic [4:0] off = 5'h00;
    logic [2:0] nsl = 3'h1;
    int cyc = 0;
    int n_errors = 0;
    int n_tests = 0;
    trs_proc_slice_type [10:0] link;
    logic [87:0] jets;
    logic [12:0] daq;
    logic [1:0] region_of_interest;
    logic dv, rdv, trig, ovf;
    logic [12:0][444:0] dpkt;
    logic [1:0][48:0] rpkt;
    int dlen, devs, rlen, revs;

    // Every sample is a function of the tick, so a packet names its tick.
    function automatic trs_proc_slice_type link_of(int p, logic [11:0] c);
        trs_proc_slice_type r;
        for (int w = 0; w < 8; w++)
            r[w] = {8'(c + p), 3'(w)};
        return r;
    endfunction : link_of
    function automatic logic [23:0] jet_of(logic [11:0] c);
        return {c, ~c};
    endfunction : jet_of
    function automatic logic [23:0] en_of(logic [11:0] c);
        return {c, c} ^ 24'h5A5A5A;
    endfunction : en_of
    function automatic logic [87:0] jets_of(logic [11:0] c);
        trs_jet_type [7:0] j;
        for (int k = 0; k < 8; k++)
            j[k] = {2'(k), c[0], 8'(c + k)};
        return j;
    endfunction : jets_of
    function automatic logic [87:0] lane_exp(int l, logic [11:0] b);
        logic [23:0] j;
        logic [23:0] e;
        j = jet_of(b);
        e = en_of(b);
        if (l < 11)
            return link_of(l, b);
        return l == 11 ? {38'h0, ~^j, j, ~^e, e} : {76'h0, b};
    endfunction : lane_exp

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(negedge mclk) cyc <= cyc + 1;
    always_comb begin
        for (int p = 0; p < 11; p++)
            link[p] = link_of(p, cyc[11:0]);
    end
    assign jets = jets_of(cyc[11:0]);

    trs_readout #(.PIPE_DEPTH(48), .FIFO_DEPTH(16)) DUT (
        .mclk(mclk), .resetn(resetn), .level1_accept_input(acc),
        .read_offset(off), .slice_count(nsl), .link_samples(link),
        .bunch_count_id(cyc[11:0]), .jet_count(jet_of(cyc[11:0])),
        .energy_sum(en_of(cyc[11:0])), .roi_jets(jets),
        .daq_stream(daq), .daq_stream_data_valid(dv), .roi_stream(region_of_interest),
        .roi_stream_data_valid(rdv), .readout_trigger(trig),
        .readout_overflow(ovf)
    );
    trs_collector PARTNER (
        .mclk(mclk), .resetn(resetn), .daq_stream(daq),
        .daq_stream_data_valid(dv), .roi_stream(region_of_interest),
        .roi_stream_data_valid(rdv), .daq_pkt(dpkt), .daq_len(dlen),
        .daq_events(devs), .roi_pkt(rpkt), .roi_len(rlen),
        .roi_events(revs)
    );

    task automatic check(string what, logic [87:0] seen, logic [87:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("Counts: %0d checks, %0d mismatches", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out
    task automatic pulse();
        @(negedge mclk);
        acc = 1'b1;
        @(negedge mclk);
        acc = 1'b0;
    endtask : pulse
    // Waits for event counts; lows counts idle DAQ ticks on the way.
    task automatic wait_ev(input int td, input int tr, output int lows);
        lows = 0;
        for (int k = 0; devs < td || revs < tr; k++) begin
            if (k == 3000) begin
                n_errors++;
                $display("unexpected timeout: expected %0d seen %0d", td, devs);
                close_out();
            end
            @(negedge mclk);
            if (devs < td && dv !== 1'b1)
                lows++;
        end
    endtask : wait_ev

    task automatic t_reset();
        resetn = 1'b0;
        repeat (10) @(negedge mclk);
        check("outputs in reset", {ovf, trig, dv, rdv, daq, region_of_interest}, 19'h0);
        resetn = 1'b1;
        @(negedge mclk);
        check("outputs after reset", {ovf, trig, dv, rdv, daq, region_of_interest}, 19'h0);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_event(input logic [4:0] o, input logic [2:0] s);
        int oe, ne, k, d0, r0, lows;
        logic [11:0] b;
        logic [87:0] jv;
        logic [88:0] ch;
        oe = o > 5'h10 ? 16 : o;
        ne = s == 3'h0 ? 1 : s > 3'h5 ? 5 : s;
        off = o;
        nsl = s;
        repeat (50) @(negedge mclk);
        d0 = devs;
        r0 = revs;
        pulse();
        for (k = 1; trig !== 1'b1 && k < 40; k++) begin
            @(posedge mclk);
            #1;
        end
        check("trigger delay", k, oe + 3);
        b = 12'(cyc - 47);
        for (k = 0; trig === 1'b1 && k < 10; k++) begin
            @(posedge mclk);
            #1;
        end
        check("trigger length", k, ne);
        wait_ev(d0 + 1, r0 + 1, lows);
        check("slice bits", dlen, 89 * ne);
        check("roi bits", rlen, 49);
        check("events", {devs - d0, revs - r0}, {32'd1, 32'd1});
        for (int i = 0; i < ne; i++)
            for (int l = 0; l < 13; l++) begin
                ch = 89'(dpkt[l] >> ((ne - 1 - i) * 89));
                check("daq payload", ch[88:1], lane_exp(l, 12'(b + i)));
                check("daq parity", ch[0], ~^ch[88:1]);
            end
        jv = jets_of(b);
        for (int l = 0; l < 2; l++) begin
            check("roi payload", rpkt[l][48:1],
                l ? {b[7:4], jv[87:44]} : {b[3:0], jv[43:0]});
            check("roi parity", rpkt[l][0], ~^rpkt[l][48:1]);
        end
        $display("t_event offset %0d slices %0d done", o, s);
    endtask : t_event
    task automatic t_burst(input logic [2:0] s, input int n);
        int d0, r0, lows;
        off = 5'h01;
        nsl = s;
        repeat (50) @(negedge mclk);
        d0 = devs;
        r0 = revs;
        repeat (n) begin
            pulse();
            repeat (7) @(negedge mclk);
        end
        if (s == 3'h5) begin
            check("overflow flag", ovf, 1'b1);
        end else begin
            wait_ev(d0 + n, r0 + n, lows);
            check("separator ticks", lows, n);
            check("last event bits", dlen, 89 * s);
            check("overflow flag", ovf, 1'b0);
        end
        $display("t_burst slices %0d events %0d done", s, n);
    endtask : t_burst

    initial begin
        t_reset();
        t_event(5'h00, 3'h1);
        t_event(5'h10, 3'h2);
        t_event(5'h05, 3'h3);
        t_event(5'h09, 3'h4);
        t_event(5'h1F, 3'h5);
        t_event(5'h02, 3'h0);
        t_event(5'h01, 3'h7);
        t_burst(3'h2, 3);
        t_burst(3'h5, 6);
        t_reset();
        t_event(5'h04, 3'h3);
        close_out();
    end
endmodule : trs_readout_tb
